// [host_serial_model.sv]
// Host terminal serial port model facing the modem serial port.
`timescale 1ns/100ps

module host_serial_model (
   // Clock
   input  wire logic CLK,
   // Serial lines
   input  wire logic TXD,
   output logic      RXD,
   // Handshake lines, active low
   output logic      DTR_N,
   output logic      CTS_N
);
   int          div     = 217;
   int          nb      = 9;
   int          got_cnt = 0;
   logic [11:0] got     = '0;

   // Lines start idle and deasserted; the bench moves the handshake lines.
   initial begin
      RXD   = 1'b1;
      DTR_N = 1'b1;
      CTS_N = 1'b1;
   end

   // ----------------------------------------
   // Sending toward the device
   // ----------------------------------------
   // One start bit, then n bits lowest first, each held div cycles.
   task automatic send(input logic [11:0] bits, input int n);
      @(posedge CLK);
      RXD <= 1'b0;
      repeat (div) @(posedge CLK);
      for (int i = 0; i < n; i++) begin
         RXD <= bits[i];
         repeat (div) @(posedge CLK);
      end
      RXD <= 1'b1;
   endtask

   // ----------------------------------------
   // Receiving from the device
   // ----------------------------------------
   // Samples mid-bit; a wrong rate in the device shows up as a corrupt frame.
   always begin
      @(negedge TXD);
      repeat (div / 2) @(posedge CLK);
      for (int i = 0; i < nb; i++) begin
         repeat (div) @(posedge CLK);
         got[i] = TXD;
      end
      got_cnt++;
   end
endmodule

// [modem_uart.sv]
// Full-duplex modem serial port with APB registers, DMA requests and bit-rate detection.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`include "modem_uart_defs.svh"

// Notes on behaviour
// - One serial channel; transmitter and receiver run independently at once.
// - Frames carry 7 or 8 data bits and one or two stop bits.
// - Parity odd, even or none; sent by transmitter, checked by receiver.
// - Bit rate programmable 600 to 230400; 115200 after reset.
// - Receiver can detect the host bit rate between 1200 and 115200.
// - Bit timing comes from dividing the system clock.
// - DMA request lines let memory feed and drain data without processor.
// - Eight signals: two data lines plus six modem control lines.
// - Modem handshake lines are controlled; host sends commands and data.
// - Outgoing characters are driven on the transmit data output.
// - A ring indication output signals alerts to the host.
// - A set-ready output tells the host the modem side is ready.
module modem_uart
   import modem_uart_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // DMA requests
   output logic             TX_DMA_REQ,
   output logic             RX_DMA_REQ,
   // Serial data
   output logic             TXD,
   input  wire logic        RXD,
   // Modem control lines, active low
   output logic             RING_N,
   output logic             RTS_N,
   input  wire logic        DTR_N,
   input  wire logic        CTS_N,
   output logic             CARRIER_DETECT_OUT_N,
   output logic             DSR_N
);

   st_t st_reg;
   st_t st_next;
   logic tx_dma_next;
   logic rx_dma_next;

   // Parity bit for a character; odd parity inverts the even sum.
   function automatic logic par_bit(input logic [7:0] d, input logic [9:0] c);
      par_bit = ^(c[`C_DATA8] ? d : {1'b0, d[6:0]}) ^ (c[`C_PAR_HI:`C_PAR_LO] == `PAR_ODD);
   endfunction

   // Index of the last data bit for the selected width.
   function automatic logic [2:0] last_bit(input logic [9:0] c);
      last_bit = c[`C_DATA8] ? 3'h7 : 3'h6;
   endfunction

   // Seven-bit characters end up in the upper bits of the shifter.
   function automatic logic [7:0] rx_align(input logic [7:0] sh, input logic [9:0] c);
      rx_align = c[`C_DATA8] ? sh : {1'b0, sh[7:1]};
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // All state advances from one record so every output below is a plain flop.
   always_comb begin
      logic        acc;
      logic        done;
      logic        rd_rx;
      logic [15:0] wdiv;
      acc = PSEL & PENABLE;
      done = acc & st_reg.pready;
      rd_rx = done & ~PWRITE & (PADDR == `OFF_RXDATA);
      wdiv = PWDATA[15:0];
      st_next = st_reg;
      st_next.pready = acc & ~st_reg.pready;
      st_next.rxd_prev = RXD;

      // Read data and error are captured one cycle into the access phase.
      if (acc & ~st_reg.pready) begin
         st_next.pslverr = 1'b0;
         st_next.prdata = 32'h0000_0000;
         case (PADDR)
            `OFF_CTRL:   st_next.prdata = {22'h00_0000, st_reg.ctrl};
            `OFF_DIV:    st_next.prdata = {16'h0000, st_reg.div};
            `OFF_TXDATA: st_next.prdata = {24'h00_0000, st_reg.txh};
            `OFF_RXDATA: st_next.prdata = {24'h00_0000, st_reg.rxbuf};
            `OFF_STATUS: st_next.prdata = {23'h00_0000, st_reg.ab_done, ~DTR_N, ~CTS_N, st_reg.ovr,
                                           st_reg.ferr, st_reg.perr, st_reg.rx_full,
                                           st_reg.tx_state != TX_IDLE, st_reg.txh_full};
            default:     st_next.pslverr = 1'b1;
         endcase
      end

      // Writes take effect only at the completing edge; the clamp keeps the rate legal.
      if (done & PWRITE) begin
         case (PADDR)
            `OFF_CTRL: begin
               st_next.ctrl = PWDATA[`CTRL_W-1:0];
               if (PWDATA[`C_AUTOBAUD]) begin
                  st_next.ab_done = 1'b0;
               end
            end
            `OFF_DIV: begin
               if (wdiv < 16'(`DIV_MIN)) begin
                  st_next.div = 16'(`DIV_MIN);
               end else if (wdiv > 16'(`DIV_MAX)) begin
                  st_next.div = 16'(`DIV_MAX);
               end else begin
                  st_next.div = wdiv;
               end
            end
            `OFF_TXDATA: begin
               if (!st_reg.txh_full) begin
                  st_next.txh = PWDATA[7:0];
                  st_next.txh_full = 1'b1;
               end
            end
            `OFF_STATUS: begin
               st_next.perr = st_reg.perr & ~PWDATA[`S_PERR];
               st_next.ferr = st_reg.ferr & ~PWDATA[`S_FERR];
               st_next.ovr = st_reg.ovr & ~PWDATA[`S_OVR];
            end
            default: ;
         endcase
      end
      if (rd_rx) begin
         st_next.rx_full = 1'b0;
      end

      // Transmitter: bit time is a down-count of the clock divisor.
      if (st_reg.tx_state != TX_IDLE) begin
         st_next.tx_cnt = st_reg.tx_cnt - 16'h0001;
      end
      case (st_reg.tx_state)
         TX_IDLE: begin
            if (st_reg.txh_full && (!st_reg.ctrl[`C_CTSFLOW] || !CTS_N)) begin
               st_next.tx_sh = st_reg.txh;
               st_next.tx_par = par_bit(st_reg.txh, st_reg.ctrl);
               st_next.txh_full = 1'b0;
               st_next.tx_cnt = st_reg.div - 16'h0001;
               st_next.tx_state = TX_START;
            end
         end
         TX_START: begin
            if (st_reg.tx_cnt == 16'h0000) begin
               st_next.tx_cnt = st_reg.div - 16'h0001;
               st_next.tx_bit = 3'h0;
               st_next.tx_state = TX_DATA;
            end
         end
         TX_DATA: begin
            if (st_reg.tx_cnt == 16'h0000) begin
               st_next.tx_cnt = st_reg.div - 16'h0001;
               st_next.tx_sh = {1'b1, st_reg.tx_sh[7:1]};
               st_next.tx_bit = st_reg.tx_bit + 3'h1;
               if (st_reg.tx_bit == last_bit(st_reg.ctrl)) begin
                  st_next.tx_bit = 3'h0;
                  st_next.tx_state = (st_reg.ctrl[`C_PAR_HI:`C_PAR_LO] == `PAR_NONE) ? TX_STOP : TX_PAR;
               end
            end
         end
         TX_PAR: begin
            if (st_reg.tx_cnt == 16'h0000) begin
               st_next.tx_cnt = st_reg.div - 16'h0001;
               st_next.tx_state = TX_STOP;
            end
         end
         TX_STOP: begin
            if (st_reg.tx_cnt == 16'h0000) begin
               st_next.tx_cnt = st_reg.div - 16'h0001;
               st_next.tx_bit = 3'h1;
               if (!st_reg.ctrl[`C_STOP2] || st_reg.tx_bit == 3'h1) begin
                  st_next.tx_state = TX_IDLE;
               end
            end
         end
         default: st_next.tx_state = TX_IDLE;
      endcase
      // Line level follows the next state so it changes with the state itself.
      case (st_next.tx_state)
         TX_START: st_next.txd = 1'b0;
         TX_DATA:  st_next.txd = st_next.tx_sh[0];
         TX_PAR:   st_next.txd = st_next.tx_par;
         default:  st_next.txd = 1'b1;
      endcase

      // Receiver: samples each bit at its middle, independent of the transmitter.
      if (st_reg.rx_state != RX_IDLE && st_reg.rx_state != RX_MEAS) begin
         st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
      end
      case (st_reg.rx_state)
         RX_IDLE: begin
            if (st_reg.rxd_prev && !RXD) begin
               if (st_reg.ctrl[`C_AUTOBAUD] && !st_reg.ab_done) begin
                  st_next.rx_cnt = 16'h0001;
                  st_next.rx_state = RX_MEAS;
               end else begin
                  st_next.rx_cnt = {1'b0, st_reg.div[15:1]};
                  st_next.rx_state = RX_START;
               end
            end
         end
         RX_MEAS: begin
            // The start bit's length is one bit time; the first data bit must be high.
            if (!RXD) begin
               if (st_reg.rx_cnt != 16'hFFFF) begin
                  st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
               end
            end else if (st_reg.rx_cnt >= 16'(`AB_DIV_MIN) && st_reg.rx_cnt <= 16'(`AB_DIV_MAX)) begin
               st_next.div = st_reg.rx_cnt;
               st_next.ab_done = 1'b1;
               st_next.rx_cnt = {1'b0, st_reg.rx_cnt[15:1]};
               st_next.rx_bit = 3'h0;
               st_next.rx_state = RX_DATA;
            end else begin
               st_next.rx_state = RX_IDLE;
            end
         end
         RX_START: begin
            if (st_reg.rx_cnt == 16'h0000) begin
               st_next.rx_cnt = st_reg.div - 16'h0001;
               st_next.rx_bit = 3'h0;
               st_next.rx_state = RXD ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (st_reg.rx_cnt == 16'h0000) begin
               st_next.rx_cnt = st_reg.div - 16'h0001;
               st_next.rx_sh = {RXD, st_reg.rx_sh[7:1]};
               st_next.rx_bit = st_reg.rx_bit + 3'h1;
               if (st_reg.rx_bit == last_bit(st_reg.ctrl)) begin
                  st_next.rx_pbad = 1'b0;
                  st_next.rx_state = (st_reg.ctrl[`C_PAR_HI:`C_PAR_LO] == `PAR_NONE) ? RX_STOP : RX_PAR;
               end
            end
         end
         RX_PAR: begin
            if (st_reg.rx_cnt == 16'h0000) begin
               st_next.rx_cnt = st_reg.div - 16'h0001;
               st_next.rx_pbad = RXD != par_bit(rx_align(st_reg.rx_sh, st_reg.ctrl), st_reg.ctrl);
               st_next.rx_state = RX_STOP;
            end
         end
         RX_STOP: begin
            // Only the first stop bit is checked, so two-stop senders are also accepted.
            if (st_reg.rx_cnt == 16'h0000) begin
               st_next.rxbuf = rx_align(st_reg.rx_sh, st_reg.ctrl);
               st_next.ovr = st_next.ovr | (st_reg.rx_full & ~rd_rx);
               st_next.rx_full = 1'b1;
               st_next.perr = st_next.perr | st_reg.rx_pbad;
               st_next.ferr = st_next.ferr | ~RXD;
               st_next.rx_state = RX_IDLE;
            end
         end
         default: st_next.rx_state = RX_IDLE;
      endcase
      tx_dma_next = ~st_next.txh_full;
      rx_dma_next = st_next.rx_full;
   end

   // ----------------------------------------
   // State register and outputs
   // ----------------------------------------
   // Reset loads constants only; the divisor starts at the default rate.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_reg <= '0;
         st_reg.ctrl <= `CTRL_RST;
         st_reg.div <= 16'(`DIV_DEF);
         st_reg.txd <= 1'b1;
         st_reg.rxd_prev <= 1'b1;
         TX_DMA_REQ <= 1'b1;
         RX_DMA_REQ <= 1'b0;
         RING_N <= 1'b1;
         RTS_N <= 1'b1;
         CARRIER_DETECT_OUT_N <= 1'b1;
         DSR_N <= 1'b1;
      end else begin
         st_reg <= st_next;
         TX_DMA_REQ <= tx_dma_next;
         RX_DMA_REQ <= rx_dma_next;
         RING_N <= ~st_next.ctrl[`C_RING];
         RTS_N <= ~st_next.ctrl[`C_RTS];
         CARRIER_DETECT_OUT_N <= ~st_next.ctrl[`C_CD];
         DSR_N <= ~st_next.ctrl[`C_DSR];
      end
   end

   assign TXD = st_reg.txd;
   assign PRDATA = st_reg.prdata;
   assign PREADY = st_reg.pready;
   assign PSLVERR = st_reg.pslverr;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   sequence tx_launch;
      st_reg.tx_state == TX_IDLE ##1 st_reg.tx_state == TX_START;
   endsequence

   chk_tx_idle_high: assert property (st_reg.tx_state == TX_IDLE |-> TXD)
      else $error("Transmit line low while idle.");
   chk_tx_start_low: assert property (tx_launch |-> !TXD [*8])
      else $error("Start bit not held low.");
   chk_tx_stop_high: assert property (st_reg.tx_state == TX_STOP |-> TXD)
      else $error("Stop bit not high.");
   chk_cts_holds_tx: assert property (st_reg.tx_state == TX_IDLE && st_reg.ctrl[`C_CTSFLOW] && CTS_N
                                      |=> st_reg.tx_state == TX_IDLE)
      else $error("Character started without clear-to-send.");
   chk_div_in_range: assert property (st_reg.div >= 16'(`DIV_MIN) && st_reg.div <= 16'(`DIV_MAX))
      else $error("Divisor outside legal rate range.");
   chk_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("APB answer not a single cycle after access.");
   chk_rx_dma_req: assert property (st_reg.rx_state == RX_STOP && st_reg.rx_cnt == 16'h0000
                                    |=> RX_DMA_REQ)
      else $error("Receive DMA request missing after a character.");
   chk_rx_read_clear: assert property (PSEL && PENABLE && PREADY && !PWRITE && PADDR == `OFF_RXDATA
                                       && st_reg.rx_state != RX_STOP |=> !st_reg.rx_full)
      else $error("Receive data not released by read.");
endmodule

// [modem_uart_defs.svh]
// Offsets, field positions, reset values and timing figures of the modem serial port.
`ifndef MODEM_UART_DEFS_SVH
`define MODEM_UART_DEFS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ      25000000
`define BAUD_DEF    115200
`define BAUD_MAX    230400
`define BAUD_MIN    600
`define AB_BAUD_MAX 115200
`define AB_BAUD_MIN 1200
`define DIV_DEF     (`CLK_HZ / `BAUD_DEF)
`define DIV_MIN     (`CLK_HZ / `BAUD_MAX)
`define DIV_MAX     (`CLK_HZ / `BAUD_MIN)
`define AB_DIV_MIN  (`CLK_HZ / `AB_BAUD_MAX)
`define AB_DIV_MAX  (`CLK_HZ / `AB_BAUD_MIN)
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL    8'h00
`define OFF_DIV     8'h04
`define OFF_TXDATA  8'h08
`define OFF_RXDATA  8'h0C
`define OFF_STATUS  8'h10
// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define C_DATA8     0
`define C_STOP2     1
`define C_PAR_LO    2
`define C_PAR_HI    3
`define C_AUTOBAUD  4
`define C_RTS       5
`define C_DSR       6
`define C_CD        7
`define C_RING      8
`define C_CTSFLOW   9
`define CTRL_W      10
`define CTRL_RST    10'h061
`define PAR_NONE    2'h0
`define PAR_ODD     2'h1
`define PAR_EVEN    2'h2
// ----------------------------------------
// Status fields
// ----------------------------------------
`define S_TXFULL    0
`define S_TXBUSY    1
`define S_RXFULL    2
`define S_PERR      3
`define S_FERR      4
`define S_OVR       5
`define S_CTS       6
`define S_DTR       7
`define S_ABDONE    8
`endif

// [modem_uart_pkg.sv]
// Types of the modem serial port: state enumerations and the state record.
package modem_uart_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_MEAS, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
   typedef struct packed {
      logic [9:0]  ctrl;
      logic [15:0] div;
      logic [7:0]  txh;
      logic        txh_full;
      tx_state_t   tx_state;
      logic [7:0]  tx_sh;
      logic [15:0] tx_cnt;
      logic [2:0]  tx_bit;
      logic        tx_par;
      logic        txd;
      rx_state_t   rx_state;
      logic [7:0]  rx_sh;
      logic [15:0] rx_cnt;
      logic [2:0]  rx_bit;
      logic        rx_pbad;
      logic        rxd_prev;
      logic [7:0]  rxbuf;
      logic        rx_full;
      logic        perr;
      logic        ferr;
      logic        ovr;
      logic        ab_done;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } st_t;
endpackage

// [tb.sv]
// Self-checking bench of the modem serial port.
`timescale 1ns/100ps
`include "modem_uart_defs.svh"

module tb;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        tx_dma_req, rx_dma_req, txd, rxd, dtr_n, cts_n;
   logic        ring_n, rts_n, carrier_detect_out_n, dsr_n;
   int          n_fail = 0;
   int          checks = 0;

   modem_uart dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_DMA_REQ(tx_dma_req),
      .RX_DMA_REQ(rx_dma_req), .TXD(txd), .RXD(rxd), .RING_N(ring_n), .RTS_N(rts_n), .DTR_N(dtr_n),
      .CTS_N(cts_n), .CARRIER_DETECT_OUT_N(carrier_detect_out_n), .DSR_N(dsr_n));
   host_serial_model host (.CLK(clk), .TXD(txd), .RXD(rxd), .DTR_N(dtr_n), .CTS_N(cts_n));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_up(input string name);
      chk(name, 32'h0, 32'h1);
      final_report;
   endtask

   // The request stands until the rising edge that samples pready high; data is taken at that edge.
   // One idle edge follows so the next call never lowers and raises psel in one time step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) give_up("apb ready");
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // Bits after the start bit: data, optional parity, stop bits; returns their count.
   function automatic int mkframe(input logic [7:0] d, input logic [9:0] c, output logic [11:0] f);
      int   n;
      logic p;
      n = c[`C_DATA8] ? 8 : 7;
      f = '1;
      for (int i = 0; i < n; i++) f[i] = d[i];
      p = ^(c[`C_DATA8] ? d : {1'b0, d[6:0]});
      if (c[3:2] != `PAR_NONE) begin
         f[n] = (c[3:2] == `PAR_ODD) ? ~p : p;
         n++;
      end
      return n + (c[`C_STOP2] ? 2 : 1);
   endfunction

   task automatic setup(input logic [9:0] c, input int dv, input int n);
      wr(`OFF_DIV, 32'(dv));
      wr(`OFF_CTRL, {22'h0, c});
      host.div = dv;
      host.nb = n;
   endtask

   task automatic wait_got(input int c0, input int lim);
      int k;
      k = 0;
      while (host.got_cnt == c0 && k < lim) begin
         @(posedge clk);
         k++;
      end
      if (k >= lim) give_up("serial frame");
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("txd idle", 32'(txd), 32'h1);
      chk("modem lines", 32'({rts_n, dsr_n, ring_n, carrier_detect_out_n}), 32'h3);
      chk("dma lines", 32'({tx_dma_req, rx_dma_req}), 32'h2);
      rd(`OFF_CTRL);
      chk("ctrl reset", r, 32'h0000_0061);
      rd(`OFF_DIV);
      chk("div reset", r, 32'd217);
      wr(`OFF_DIV, 32'd50);
      rd(`OFF_DIV);
      chk("div low clamp", r, 32'd108);
      wr(`OFF_DIV, 32'd60000);
      rd(`OFF_DIV);
      chk("div high clamp", r, 32'd41666);
      rd(8'h14);
      chk("unmapped", {e, r[30:0]}, 32'h8000_0000);
      $display("test reset done");
   endtask

   task automatic t_tx(input logic [9:0] c, input int dv, input logic [7:0] d);
      logic [11:0] f;
      int          n, c0, m;
      n = mkframe(d, c, f);
      m = (1 << n) - 1;
      setup(c, dv, n);
      c0 = host.got_cnt;
      wr(`OFF_TXDATA, {24'h0, d});
      wait_got(c0, 14 * dv);
      chk("tx frame", 32'(host.got) & m, 32'(f) & m);
      $display("test tx done");
   endtask

   // Sends and receives at once; a bad parity bit must be flagged and cleared.
   task automatic t_rx(input logic [9:0] c, input int dv, input logic [7:0] d, input logic bad);
      logic [11:0] f, g;
      int          n, c0, m;
      n = mkframe(d, c, f);
      void'(mkframe(~d, c, g));
      m = (1 << n) - 1;
      if (bad) f[n - (c[`C_STOP2] ? 3 : 2)] ^= 1'b1;
      setup(c, dv, n);
      c0 = host.got_cnt;
      wr(`OFF_TXDATA, {24'h0, ~d});
      host.send(f, n);
      wait_got(c0, 14 * dv);
      chk("duplex tx", 32'(host.got) & m, 32'(g) & m);
      chk("rx dma req", 32'(rx_dma_req), 32'h1);
      rd(`OFF_RXDATA);
      chk("rx data", r, c[`C_DATA8] ? {24'h0, d} : {25'h0, d[6:0]});
      chk("rx dma idle", 32'(rx_dma_req), 32'h0);
      rd(`OFF_STATUS);
      chk("parity flag", 32'(r[`S_PERR]), 32'(bad));
      wr(`OFF_STATUS, 32'h0000_0038);
      rd(`OFF_STATUS);
      chk("parity clear", 32'(r[`S_PERR]), 32'h0);
      $display("test rx done");
   endtask

   task automatic t_cts;
      int lows, c0;
      lows = 0;
      setup(10'h261, 108, 9);
      c0 = host.got_cnt;
      wr(`OFF_TXDATA, 32'h0000_0042);
      repeat (1500) begin
         @(posedge clk);
         lows += (txd === 1'b0);
      end
      chk("held by cts", 32'(lows), 32'h0);
      chk("tx dma held", 32'(tx_dma_req), 32'h0);
      host.CTS_N <= 1'b0;
      wait_got(c0, 1500);
      chk("tx after cts", 32'(host.got[8:0]), 32'h142);
      $display("test cts done");
   endtask

   task automatic t_modem;
      host.DTR_N <= 1'b0;
      wr(`OFF_CTRL, 32'h0000_0181);
      chk("ring cd out", 32'({ring_n, carrier_detect_out_n}), 32'h0);
      chk("rts dsr off", 32'({rts_n, dsr_n}), 32'h3);
      rd(`OFF_STATUS);
      chk("cts dtr seen", 32'(r[7:6]), 32'h3);
      host.DTR_N <= 1'b1;
      wr(`OFF_CTRL, 32'h0000_0061);
      rd(`OFF_STATUS);
      chk("dtr released", 32'(r[`S_DTR]), 32'h0);
      chk("modem restored", 32'({rts_n, dsr_n, ring_n, carrier_detect_out_n}), 32'h3);
      $display("test modem done");
   endtask

   // The host runs at 57600 bit/s; the receiver must adopt the measured bit length.
   task automatic t_auto;
      logic [11:0] f;
      int          n;
      n = mkframe(8'h41, 10'h061, f);
      setup(10'h071, 108, n);
      host.div = 434;
      host.send(f, n);
      rd(`OFF_RXDATA);
      chk("autobaud char", r, 32'h0000_0041);
      rd(`OFF_STATUS);
      chk("autobaud done", 32'(r[`S_ABDONE]), 32'h1);
      rd(`OFF_DIV);
      chk("autobaud div", 32'(r >= 433 && r <= 435), 32'h1);
      $display("test autobaud done");
   endtask

   // ----------------------------------------
   // Clock, reset and sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      {rstn, psel, penable, pwrite} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      t_reset;
      t_tx(10'h061, 108, 8'hA5);
      t_tx(10'h066, 217, 8'h5B);
      t_tx(10'h069, 108, 8'h3C);
      t_tx(10'h062, 108, 8'h71);
      t_tx(10'h06D, 108, 8'h96);
      t_rx(10'h069, 217, 8'h5A, 1'b0);
      t_rx(10'h066, 108, 8'h33, 1'b1);
      t_rx(10'h061, 108, 8'hC3, 1'b0);
      t_cts;
      t_modem;
      t_auto;
      final_report;
   end
endmodule
